// file: rtl/wdt_pkg.sv
// Package: constants, field layouts and carriers for the watchdog block
package wdt_pkg;

	// Clock rates and the derived tick divider
	localparam int unsigned SYS_CLK_HZ = 250_000_000;
	localparam int unsigned WDOG_OSC_HZ = 128_000;
	localparam int unsigned TICK_DIV = SYS_CLK_HZ / WDOG_OSC_HZ;

	// Change window length in system clock cycles
	localparam int unsigned UNLOCK_CYCLES = 4;

	// Time-out base in oscillator cycles, code 0 of period_select
	localparam int unsigned BASE_TICKS = 2048;
	localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;

	// Register bus widths and offsets
	localparam int unsigned ADDR_W = 2;
	localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE = 2'h0;
	localparam logic [ADDR_W-1:0] OFS_WDOG_CTRL = 2'h1;

	// Reset-cause field positions
	localparam int unsigned RC_POWERON = 0;
	localparam int unsigned RC_PIN = 1;
	localparam int unsigned RC_BROWNOUT = 2;
	localparam int unsigned RC_WDOG = 3;

	// Control/status field positions
	localparam int unsigned CS_SEL0 = 0;
	localparam int unsigned CS_SEL2 = 2;
	localparam int unsigned CS_WDOG_ON = 3;
	localparam int unsigned CS_UNLOCK = 4;
	localparam int unsigned CS_SEL3 = 5;
	localparam int unsigned CS_IRQ_ON = 6;
	localparam int unsigned CS_IRQ_FLAG = 7;

	// Reset values
	localparam logic RST_POWERON_FLAG = 1'b1;
	localparam logic RST_OTHER_FLAG = 1'b0;
	localparam logic [3:0] RST_PERIOD = 4'h0;

	// Register bus request carrier
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} wdt_bus_s;

	// Raw reset-source levels from the analog side
	typedef struct packed {
		logic brownout;
		logic pin;
	} wdt_src_s;

endpackage

// file: rtl/wdt_core.sv
// Watchdog timer with timed change sequence and reset-cause flags
// What this block does
// RULE1: Level 1 starts disabled; writing one to enable turns it on freely.
// RULE2: Level 1 disable: unlock+enable write, then within four cycles the wanted value.
// RULE3: Level 2 always runs; enable reads back as one.
// RULE4: Level 2 period change: unlock+enable write, then period within four cycles.
// RULE5: Reset-cause bits 7..4 read zero.
// RULE6: Watchdog-reset flag bit 3 set by watchdog reset, cleared by power-on or zero write.
// RULE7: Brown-out flag bit 2 set by brown-out, cleared by power-on or zero write.
// RULE8: Pin-reset flag bit 1 set by pin reset, cleared by power-on or zero write.
// RULE9: Power-on flag bit 0 set at power-on, cleared only by zero write.
// RULE10: Interrupt flag bit 7 set on time-out in interrupt mode; vector or one-write clears.
// RULE11: Interrupt requested only with global and time-out interrupt enables set.
// RULE12: Enable/irq-enable pair: 00 stopped, 01 irq, 10 reset, 11 irq.
// RULE13: Time-out with both set clears irq-enable, so next time-out resets; the code clears it only once the vector is taken.
// RULE14: Unlock bit 4 self-clears after four cycles; needed to disable or change period.
// RULE15: Enable accepts a zero only while unlock is set.
// RULE16: Level 2 never disables, even with a correct sequence.
// RULE17: Level 1 enable forced to one while watchdog-reset flag is set.
// RULE18: Period select bits 5,2..0; codes 0..9 give 2K..1024K ticks, rest reserved.
// RULE19: Unused-watchdog software clears reset flag and enable at start-up.
// RULE20: Counter advances on a 128 kHz tick, not the system clock.
// RULE21: Counter cleared by restart, when disabled, and on any chip reset.
// RULE22: Reset-mode time-out gives a one-cycle reset request.
// RULE23: Restart, disable and time-out events cross rate boundaries without loss.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module wdt_core #(
	parameter int unsigned BASE = wdt_pkg::BASE_TICKS,
	parameter int unsigned DIV = wdt_pkg::TICK_DIV
) (
	input wire logic clk,
	input wire logic nrst,
	input wire wdt_pkg::wdt_bus_s bus,
	output logic [7:0] rdata,
	input wire wdt_pkg::wdt_src_s src,
	input wire logic safety_level_fuse,
	input wire logic timer_restart_instr,
	input wire logic irq_taken,
	input wire logic global_irq_on,
	output logic irq_req,
	output logic rst_req
);
	import wdt_pkg::*;

	localparam int unsigned CNT_W = 22;
	localparam int unsigned DIV_W = 16;

	// Two-flop synchronisers for pin-side levels, third flop for edges
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [1:0] sync3;
	wire logic [2:0] sync_in = {safety_level_fuse, src.brownout, src.pin};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			sync3 <= 2'h0;
		end else begin
			sync1 <= sync_in;
			sync2 <= sync1;
			sync3 <= sync2[1:0];
		end
	end

	// Fuse set means safety level 2
	wire logic level2 = sync2[2];
	wire logic bor_evt = sync2[1] & ~sync3[1];
	wire logic pin_evt = sync2[0] & ~sync3[0];

	// Control and status state
	logic wdog_on;
	logic timeout_irq_on;
	logic timeout_irq_flag;
	logic [3:0] period_select;
	logic [2:0] unlock_cnt;
	logic wdog_reset_flag;
	logic brownout_reset_flag;
	logic pin_reset_flag;
	logic poweron_reset_flag;
	logic [CNT_W-1:0] count;
	logic [DIV_W-1:0] div_cnt;

	// Any reset other than power-on returns the control side to its start state
	wire logic chip_reset = rst_req | bor_evt | pin_evt;

	// Register decode
	wire logic sel_rc = bus.addr == OFS_RESET_CAUSE;
	wire logic sel_cs = bus.addr == OFS_WDOG_CTRL;
	wire logic wr_rc = bus.wr & sel_rc;
	wire logic wr_cs = bus.wr & sel_cs;
	wire logic w_on = bus.wdata[CS_WDOG_ON];
	wire logic w_unlock = bus.wdata[CS_UNLOCK];
	wire logic [3:0] w_sel = {bus.wdata[CS_SEL3], bus.wdata[CS_SEL2:CS_SEL0]};

	// Change window open while the unlock count runs
	wire logic change_unlock = unlock_cnt != 3'h0; // RULE14
	wire logic unlock_start = wr_cs & w_unlock & w_on; // RULE2 RULE4
	wire logic unlock_use = wr_cs & change_unlock & ~w_unlock; // RULE2 RULE4

	// Effective enable seen by software and by the counter
	wire logic on_eff = level2 | wdog_on | wdog_reset_flag; // RULE3 RULE17
	wire logic running = on_eff | timeout_irq_on; // RULE12

	// Period decode, reserved codes fall back to the longest period
	function automatic logic [CNT_W-1:0] period_ticks(input logic [3:0] code);
		logic [3:0] c;
		c = (code > PERIOD_MAX_CODE) ? PERIOD_MAX_CODE : code;
		period_ticks = CNT_W'(BASE) << c; // RULE18
	endfunction

	wire logic [CNT_W-1:0] limit = period_ticks(period_select) - CNT_W'(1);

	// Tick divider makes the oscillator rate as a one-cycle enable
	wire logic tick = div_cnt == DIV_W'(DIV - 1); // RULE20

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt <= '0;
		end else if (tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + DIV_W'(1);
		end
	end

	// Time-out: the last tick of the period while running
	wire logic timeout = running & tick & (count >= limit);
	wire logic to_irq = timeout & timeout_irq_on; // RULE12
	wire logic to_reset = timeout & on_eff & ~timeout_irq_on; // RULE12

	// Counter; restart, disable and reset all act in the same clock domain,
	// so no event can be dropped or repeated between rates
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
		end else if (chip_reset | timer_restart_instr | ~running | timeout) begin
			count <= '0; // RULE21 RULE23
		end else if (tick) begin
			count <= count + CNT_W'(1); // RULE20
		end
	end

	// One-cycle reset request on a reset-mode time-out
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_req <= 1'b0;
		end else begin
			rst_req <= to_reset & ~rst_req; // RULE22
		end
	end

	// Unlock window counter, restarts on every unlock write that also sets enable
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			unlock_cnt <= 3'h0;
		end else if (chip_reset | unlock_use) begin
			unlock_cnt <= 3'h0;
		end else if (unlock_start) begin
			unlock_cnt <= 3'(UNLOCK_CYCLES); // RULE14
		end else if (change_unlock) begin
			unlock_cnt <= unlock_cnt - 3'h1;
		end
	end

	// Enable bit: set freely, cleared only inside the window at level 1
	logic next_wdog_on;
	always_comb begin
		next_wdog_on = wdog_on;
		if (wr_cs) begin
			if (w_on) begin
				next_wdog_on = 1'b1; // RULE1
			end else if (unlock_use & ~level2 & ~wdog_reset_flag) begin
				next_wdog_on = 1'b0; // RULE15 RULE16 RULE17
			end
		end
	end

	// Period select: changes only inside the window
	wire logic [3:0] next_period = unlock_use ? w_sel : period_select; // RULE14 RULE4

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wdog_on <= 1'b0;
			period_select <= RST_PERIOD;
		end else if (chip_reset) begin
			wdog_on <= 1'b0; // RULE1
			period_select <= RST_PERIOD;
		end else begin
			wdog_on <= next_wdog_on;
			period_select <= next_period;
		end
	end

	// Interrupt enable: software writes; with enable set, the serviced time-out clears it.
	// Clearing at the time-out edge itself would mask the request it raises,
	// so the clear waits for the vector to be taken
	logic next_irq_on;
	always_comb begin
		next_irq_on = timeout_irq_on;
		if (wr_cs) begin
			next_irq_on = bus.wdata[CS_IRQ_ON];
		end
		if (irq_taken & on_eff & timeout_irq_flag) begin
			next_irq_on = 1'b0; // RULE13
		end
	end

	// Interrupt flag: set wins over vector-taken or write-one clear
	wire logic flag_clr = irq_taken | (wr_cs & bus.wdata[CS_IRQ_FLAG]); // RULE10

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timeout_irq_on <= 1'b0;
			timeout_irq_flag <= 1'b0;
		end else if (chip_reset) begin
			timeout_irq_on <= 1'b0;
			timeout_irq_flag <= 1'b0;
		end else begin
			timeout_irq_on <= next_irq_on;
			if (to_irq) begin
				timeout_irq_flag <= 1'b1; // RULE10
			end else if (flag_clr) begin
				timeout_irq_flag <= 1'b0;
			end
		end
	end

	// Request needs the flag, both enables; combinational handshake output
	assign irq_req = timeout_irq_flag & timeout_irq_on & global_irq_on; // RULE11

	// Reset-cause flags; power-on reset is the block reset itself
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			poweron_reset_flag <= RST_POWERON_FLAG; // RULE9
			wdog_reset_flag <= RST_OTHER_FLAG; // RULE6
			brownout_reset_flag <= RST_OTHER_FLAG; // RULE7
			pin_reset_flag <= RST_OTHER_FLAG; // RULE8
		end else begin
			if (wr_rc & ~bus.wdata[RC_POWERON]) begin
				poweron_reset_flag <= 1'b0; // RULE9
			end
			if (rst_req) begin
				wdog_reset_flag <= 1'b1; // RULE6
			end else if (wr_rc & ~bus.wdata[RC_WDOG]) begin
				wdog_reset_flag <= 1'b0;
			end
			if (bor_evt) begin
				brownout_reset_flag <= 1'b1; // RULE7
			end else if (wr_rc & ~bus.wdata[RC_BROWNOUT]) begin
				brownout_reset_flag <= 1'b0;
			end
			if (pin_evt) begin
				pin_reset_flag <= 1'b1; // RULE8
			end else if (wr_rc & ~bus.wdata[RC_PIN]) begin
				pin_reset_flag <= 1'b0;
			end
		end
	end

	// Read views; upper reset-cause bits are tied low
	wire logic [7:0] rc_view = {4'h0, wdog_reset_flag, brownout_reset_flag,
		pin_reset_flag, poweron_reset_flag}; // RULE5
	wire logic [7:0] cs_view = {timeout_irq_flag, timeout_irq_on, period_select[3],
		change_unlock, on_eff, period_select[2:0]}; // RULE3
	wire logic [7:0] rd_mux = sel_rc ? rc_view : (sel_cs ? cs_view : 8'h00);

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			rdata <= rd_mux;
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule // wdt_core

`default_nettype wire

// file: bench/wdt_props.sv
// Checker: port-level properties of the watchdog core
`timescale 1ns/1ns
`default_nettype none
module wdt_props import wdt_pkg::*; #(
	parameter int unsigned BASE = BASE_TICKS,
	parameter int unsigned DIV = TICK_DIV
) (
	input wire logic clk,
	input wire logic nrst,
	input wire wdt_pkg::wdt_bus_s bus,
	input wire logic [7:0] rdata,
	input wire wdt_pkg::wdt_src_s src,
	input wire logic safety_level_fuse,
	input wire logic timer_restart_instr,
	input wire logic irq_taken,
	input wire logic global_irq_on,
	input wire logic irq_req,
	input wire logic rst_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Counter restarts on each time-out, so pulses never crowd
	AST_RST_PULSE: assert property (rst_req |=> !rst_req [*4])
		else $error("reset request longer than one cycle");
	AST_CAUSE_RSVD: assert property ($past(bus.rd) && $past(bus.addr) == OFS_RESET_CAUSE |-> rdata[7:4] == 4'h0)
		else $error("reserved cause bits not zero");
	AST_IRQ_GATE: assert property (irq_req |-> global_irq_on)
		else $error("interrupt without global enable");
	AST_IRQ_TAKEN: assert property (irq_taken && !rst_req |=> !irq_req)
		else $error("vector taken left flag set");
	AST_RST_CLEARS: assert property (rst_req |-> ##2 !irq_req)
		else $error("chip reset left interrupt pending");
	AST_RST_NOT_IRQ: assert property (rst_req |-> !irq_req)
		else $error("reset and interrupt on one time-out");
	AST_LVL2_ON: assert property ($past(bus.rd) && $past(bus.addr) == OFS_WDOG_CTRL && safety_level_fuse
		&& $past(safety_level_fuse, 4) && $past(nrst, 4) |-> rdata[3]) else $error("level 2 enable reads zero");
	// Exactly five cycles after the unlock write the bit is gone
	AST_UNLOCK_EXPIRE: assert property (bus.wr && bus.addr == OFS_WDOG_CTRL && bus.wdata[4] && bus.wdata[3]
		##1 (!bus.wr) [*4] ##1 (bus.rd && bus.addr == OFS_WDOG_CTRL) |=> !rdata[4]) else $error("unlock stayed open");
endmodule // wdt_props
`default_nettype wire

// file: bench/testbench.sv
// Testbench: table cases and hand-written sequences for the watchdog core
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import wdt_pkg::*;
	typedef struct {logic [ADDR_W-1:0] a; logic [7:0] d; bit w; logic [7:0] e;} wdt_row_s;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	wdt_bus_s bus = '0;
	wdt_src_s src = '0;
	logic safety_level_fuse = 1'b0;
	logic timer_restart_instr = 1'b0;
	logic irq_taken = 1'b0;
	logic global_irq_on = 1'b0;
	logic [7:0] rdata;
	logic irq_req;
	logic rst_req;
	int n_mismatch = 0;
	int total_checks = 0;
	int n_rst = 0;
	// Period code 15 write without unlock must be ignored in level 1
	wdt_row_s rows [5] = '{'{2'h0, 8'h00, 1, 8'h00}, '{2'h0, 8'hFF, 1, 8'h00}, '{2'h2, 8'hFF, 1, 8'h00},
		'{2'h3, 8'h00, 0, 8'h00}, '{2'h1, 8'h27, 1, 8'h00}};
	always #2 clk = ~clk;
	always @(posedge clk) if (rst_req === 1'b1) n_rst <= n_rst + 1;
	// Small counts keep time-outs within a few dozen cycles
	wdt_core #(.BASE(2), .DIV(8)) u_dut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .src(src),
		.safety_level_fuse(safety_level_fuse), .timer_restart_instr(timer_restart_instr), .irq_taken(irq_taken),
		.global_irq_on(global_irq_on), .irq_req(irq_req), .rst_req(rst_req));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 chk(rdata, e);
	endtask
	// Bounded wait for a time-out outcome
	task automatic wait_ev(input bit want_rst);
		bit hit;
		hit = 0;
		for (int i = 0; i < 300 && !hit; i++) begin
			@(posedge clk);
			#1 hit = want_rst ? (rst_req === 1'b1) : (irq_req === 1'b1);
		end
		chk({7'h00, hit}, 8'h01);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		$display("[ERR] %0t: run did not finish", $time);
		conclude();
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rdchk(OFS_RESET_CAUSE, 8'h01);
		rdchk(OFS_WDOG_CTRL, 8'h00);
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rdchk(rows[i].a, rows[i].e);
		end
		$display("reset and table done");
		// Restarts hold off the time-out, then a reset follows
		wr(OFS_WDOG_CTRL, 8'h08);
		repeat (12) begin
			@(posedge clk);
			timer_restart_instr <= 1'b1;
			@(posedge clk);
			timer_restart_instr <= 1'b0;
		end
		chk(8'(n_rst), 8'h00);
		wait_ev(1);
		rdchk(OFS_RESET_CAUSE, 8'h08);
		rdchk(OFS_WDOG_CTRL, 8'h08);
		wr(OFS_WDOG_CTRL, 8'h18);
		wr(OFS_WDOG_CTRL, 8'h00);
		rdchk(OFS_WDOG_CTRL, 8'h08);
		wait_ev(1);
		wr(OFS_RESET_CAUSE, 8'h00);
		rdchk(OFS_WDOG_CTRL, 8'h00);
		$display("reset mode done");
		wr(OFS_WDOG_CTRL, 8'h18);
		wr(OFS_WDOG_CTRL, 8'h29);
		rdchk(OFS_WDOG_CTRL, 8'h29);
		wr(OFS_WDOG_CTRL, 8'h39);
		repeat (3) @(posedge clk);
		rdchk(OFS_WDOG_CTRL, 8'h29);
		wr(OFS_WDOG_CTRL, 8'h20);
		rdchk(OFS_WDOG_CTRL, 8'h29);
		wr(OFS_WDOG_CTRL, 8'h39);
		wr(OFS_WDOG_CTRL, 8'h00);
		rdchk(OFS_WDOG_CTRL, 8'h00);
		$display("change window done");
		global_irq_on <= 1'b1;
		wr(OFS_WDOG_CTRL, 8'h40);
		wait_ev(0);
		@(posedge clk);
		irq_taken <= 1'b1;
		@(posedge clk);
		irq_taken <= 1'b0;
		rdchk(OFS_WDOG_CTRL, 8'h40);
		global_irq_on <= 1'b0;
		repeat (40) @(posedge clk);
		chk({7'h00, irq_req}, 8'h00);
		global_irq_on <= 1'b1;
		#1 chk({7'h00, irq_req}, 8'h01);
		wr(OFS_WDOG_CTRL, 8'h00);
		rdchk(OFS_WDOG_CTRL, 8'h80);
		wr(OFS_WDOG_CTRL, 8'h80);
		rdchk(OFS_WDOG_CTRL, 8'h00);
		wr(OFS_WDOG_CTRL, 8'h48);
		wait_ev(0);
		rdchk(OFS_WDOG_CTRL, 8'hC8);
		@(posedge clk);
		irq_taken <= 1'b1;
		@(posedge clk);
		irq_taken <= 1'b0;
		rdchk(OFS_WDOG_CTRL, 8'h08);
		wait_ev(1);
		wait_ev(1);
		wr(OFS_RESET_CAUSE, 8'h00);
		$display("interrupt mode done");
		// Pin event first, then brown-out on top of it
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			src <= k ? 2'b10 : 2'b01;
			repeat (6) @(posedge clk);
			src <= '0;
			repeat (6) @(posedge clk);
			rdchk(OFS_RESET_CAUSE, k ? 8'h06 : 8'h02);
		end
		wr(OFS_RESET_CAUSE, 8'h04);
		rdchk(OFS_RESET_CAUSE, 8'h04);
		$display("reset sources done");
		nrst <= 1'b0;
		safety_level_fuse <= 1'b1;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		wr(OFS_WDOG_CTRL, 8'h18);
		wr(OFS_WDOG_CTRL, 8'h21);
		rdchk(OFS_WDOG_CTRL, 8'h29);
		wr(OFS_WDOG_CTRL, 8'h18);
		wr(OFS_WDOG_CTRL, 8'h20);
		rdchk(OFS_WDOG_CTRL, 8'h28);
		rdchk(OFS_RESET_CAUSE, 8'h01);
		$display("level 2 done");
		conclude();
	end
endmodule // testbench
bind wdt_core wdt_props #(.BASE(BASE), .DIV(DIV)) u_props (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
	.src(src), .safety_level_fuse(safety_level_fuse), .timer_restart_instr(timer_restart_instr),
	.irq_taken(irq_taken), .global_irq_on(global_irq_on), .irq_req(irq_req), .rst_req(rst_req));
`default_nettype wire
